/* mcs_params.svh */
// Purpose: constants of the motor comparator sampling stage
// Assumes: 10 MHz clock, 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

`define MCS_CLK_PERIOD_NS 100
`define MCS_STARTUP_NS 3000
`define MCS_STARTUP_CYC \
  ((`MCS_STARTUP_NS + `MCS_CLK_PERIOD_NS - 1) / `MCS_CLK_PERIOD_NS)
`define MCS_TACHO_PIPE 3
`define MCS_CAPT_PIPE 2
`define MCS_DIV_BASE 6'h04

`define MCS_OFS_CTRL 8'h00
`define MCS_OFS_MASK 8'h04
`define MCS_OFS_STATUS 8'h08
`define MCS_OFS_STATE 8'h0C
`define MCS_OFS_ZCAP 8'h10
`define MCS_OFS_DCAP 8'h14
`define MCS_OFS_TCAP 8'h18

`define MCS_CTRL_W 18
`define MCS_CTRL_RST 18'h00000
`define MCS_EVT_W 3
`define MCS_MASK_RST 3'h0
`define MCS_ST_Z 0
`define MCS_ST_D 1
`define MCS_ST_T 2

`define MCS_RESP_OKAY 2'h0
`define MCS_RESP_SLVERR 2'h2

`endif

/* mcs_pkg.sv */
// Purpose: types of the motor comparator sampling stage
// Assumes: control word layout as in mcs_params.svh
// Notes: mode codes follow declaration order
package mcs_pkg;
  typedef enum logic [1:0] {
    mcs_mode_offtime,
    mcs_mode_scf,
    mcs_mode_ondelay,
    mcs_mode_tacho
  } mcs_mode_t;

  typedef struct packed {
    logic [7:0] ds;
    logic demag_sel;
    logic dac_en;
    logic cke;
    logic [2:0] vr;
    logic [1:0] scf;
    mcs_mode_t mode;
  } mcs_ctrl_t;
endpackage

/* mcs_sync.sv */
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: input may change at any time
// Notes: the first stage is read only by the second
module mcs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } mcs_sync_t;

  mcs_sync_t s_reg;
  mcs_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.ff1 = d;
    s_next.ff2 = s_reg.ff1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.ff2;
endmodule

/* mcs_scf_div.sv */
// Purpose: sampling clock divider giving a one-cycle tick
// Assumes: code 0..3 selects divide by 4, 8, 16, 32
// Notes: held in reset while disabled so the phase is known
module mcs_scf_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic [1:0] scf,
  // Tick out
  output logic tick
);
  `include "mcs_params.svh"

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } mcs_div_t;

  mcs_div_t d_reg;
  mcs_div_t d_next;
  logic [5:0] div;
  logic [4:0] last;

  assign div = `MCS_DIV_BASE << scf;
  assign last = 5'(div - 6'h01);

  always_comb begin
    d_next = d_reg;
    d_next.tick = 1'b0;
    if (!en) begin
      d_next.cnt = 5'h00;
    end else if (d_reg.cnt == last) begin
      d_next.cnt = 5'h00;
      d_next.tick = 1'b1;
    end else begin
      d_next.cnt = 5'(d_reg.cnt + 5'h01);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign tick = d_reg.tick;
endmodule

/* mcs_motor_sampler.sv */
// Purpose: digital sampling stage behind the rotor position comparator
// Assumes: phase outputs and rotor sense are synchronous to clk
// Notes: comparator output is asynchronous and is synchronised here
`include "mcs_params.svh"

// Contract
// - Tacho mode captures the timer four cycles after rotor sense toggles.
// - Off-time sampling captures timer into zero-cross register three cycles later.
// - Off-time sampling updates the sampled state one cycle after phase on.
// - Sampling-clock mode raises zero-cross within one period plus three cycles.
// - Demag event captures timer three cycles after the sampling moment.
// - On-time sampling updates state after programmed delay plus one cycle.
// - After comparator enable, wait about three microseconds before sampling.
// - Three-bit code selects reference fraction 0.04 up to 0.7 of supply.
// - Divider code 0..3 gives quarter to thirty-second of the clock.
module mcs_motor_sampler
  import mcs_pkg::*;
#(
  parameter int TW = 16,
  parameter int STARTUP_CYC = `MCS_STARTUP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Comparator and motor side
  input wire logic comp_out,
  input wire logic rotor_sense_input,
  input wire logic [5:0] phase_drive_output,
  input wire logic [TW-1:0] commutation_timer,
  // Analog controls and status
  output logic [2:0] ref_threshold_sel,
  output logic [9:0] ref_permille,
  output logic comp_clk_en,
  output logic ref_dac_en,
  output logic sampled_comparator_state,
  output logic sampling_ready,
  output logic zero_cross_event,
  output logic demag_event,
  output logic irq
);
  localparam int SUW = $clog2(STARTUP_CYC + 1);

  typedef struct packed {
    mcs_ctrl_t ctrl;
    logic [2:0] mask;
    logic [2:0] sts;
    logic irq;
    logic [SUW-1:0] su_cnt;
    logic ready;
    logic pdo_any;
    logic rs_prev;
    logic state_bit;
    logic [`MCS_CAPT_PIPE-1:0] cap_pipe;
    logic [`MCS_TACHO_PIPE-1:0] tach_pipe;
    logic [7:0] dly;
    logic dly_run;
    logic [TW-1:0] zcap;
    logic [TW-1:0] dcap;
    logic [TW-1:0] tcap;
    logic z_evt;
    logic d_evt;
    logic [9:0] ref_pm;
    logic [7:0] awaddr;
    logic aw_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_full;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcs_core_t;

  mcs_core_t q;
  mcs_core_t n;
  logic comp_s;
  logic tick;
  logic pdo_on;
  logic smp;
  logic tach_tog;
  logic [2:0] ev;

  function automatic logic [31:0] mcs_merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Reference fraction of supply in thousandths; code 111 is unused
  function automatic logic [9:0] mcs_ref_pm(input logic [2:0] code);
    logic [9:0] r;
    r = 10'h000;
    case (code)
      3'h0: r = 10'h028;
      3'h1: r = 10'h078;
      3'h2: r = 10'h0C8;
      3'h3: r = 10'h12C;
      3'h4: r = 10'h190;
      3'h5: r = 10'h1F4;
      3'h6: r = 10'h2BC;
      default: r = 10'h000;
    endcase
    return r;
  endfunction

  mcs_sync #(.W(1)) u_comp_sync (
    .clk(clk),
    .rst(rst),
    .d(comp_out),
    .q(comp_s)
  );

  mcs_scf_div u_div (
    .clk(clk),
    .rst(rst),
    .en(q.ready),
    .scf(q.ctrl.scf),
    .tick(tick)
  );

  assign pdo_on = (|phase_drive_output) && !q.pdo_any;
  assign tach_tog = q.ready && (q.ctrl.mode == mcs_mode_tacho) &&
                    (rotor_sense_input != q.rs_prev);

  // Sampling moment per mode, blocked until the start-up wait ends
  always_comb begin
    smp = 1'b0;
    case (q.ctrl.mode)
      mcs_mode_offtime: smp = pdo_on;
      mcs_mode_scf: smp = tick;
      mcs_mode_ondelay: begin
        if (q.ctrl.ds == 8'h00) begin
          smp = pdo_on;
        end else begin
          smp = q.dly_run && (q.dly == 8'h01) && !pdo_on;
        end
      end
      default: smp = 1'b0;
    endcase
    smp = smp && q.ready;
  end

  always_comb begin
    n = q;
    ev = 3'h0;
    n.z_evt = 1'b0;
    n.d_evt = 1'b0;
    n.pdo_any = |phase_drive_output;
    n.rs_prev = rotor_sense_input;

    // Start-up filter restarts whenever both enables drop
    if (!(q.ctrl.cke || q.ctrl.dac_en)) begin
      n.su_cnt = '0;
      n.ready = 1'b0;
    end else if (!q.ready) begin
      if (q.su_cnt == SUW'(STARTUP_CYC - 1)) begin
        n.ready = 1'b1;
      end else begin
        n.su_cnt = SUW'(q.su_cnt + 1'b1);
      end
    end

    // On-time delay counter, reloaded at every phase turn-on
    if (pdo_on) begin
      n.dly = q.ctrl.ds;
      n.dly_run = (q.ctrl.ds != 8'h00);
    end else if (q.dly_run) begin
      n.dly = 8'(q.dly - 8'h01);
      n.dly_run = (q.dly != 8'h01);
    end

    n.cap_pipe = {q.cap_pipe[0], smp && (comp_s != q.state_bit)};
    if (smp) begin
      n.state_bit = comp_s;
    end
    if (q.cap_pipe[`MCS_CAPT_PIPE-1]) begin
      if (q.ctrl.demag_sel) begin
        n.dcap = commutation_timer;
        n.d_evt = 1'b1;
        ev[`MCS_ST_D] = 1'b1;
      end else begin
        n.zcap = commutation_timer;
        n.z_evt = 1'b1;
        ev[`MCS_ST_Z] = 1'b1;
      end
    end

    n.tach_pipe = {q.tach_pipe[`MCS_TACHO_PIPE-2:0], tach_tog};
    if (q.tach_pipe[`MCS_TACHO_PIPE-1]) begin
      n.tcap = commutation_timer;
      ev[`MCS_ST_T] = 1'b1;
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      n.awaddr = s_axi_awaddr;
      n.aw_full = 1'b1;
    end
    if (s_axi_wvalid && q.wready) begin
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
      n.w_full = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `MCS_RESP_OKAY;
      if (q.awaddr == `MCS_OFS_CTRL) begin
        n.ctrl = mcs_ctrl_t'(mcs_merge(32'(q.ctrl), q.wdata,
                                       q.wstrb));
      end else if (q.awaddr == `MCS_OFS_MASK) begin
        if (q.wstrb[0]) begin
          n.mask = q.wdata[2:0];
        end
      end else if (q.awaddr == `MCS_OFS_STATUS ||
                   q.awaddr == `MCS_OFS_STATE ||
                   q.awaddr == `MCS_OFS_ZCAP ||
                   q.awaddr == `MCS_OFS_DCAP ||
                   q.awaddr == `MCS_OFS_TCAP) begin
        n.bresp = `MCS_RESP_OKAY;
      end else begin
        n.bresp = `MCS_RESP_SLVERR;
      end
    end
    n.awready = !n.aw_full;
    n.wready = !n.w_full;

    // Read channel; a status read clears it, new events still land
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `MCS_RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (s_axi_araddr == `MCS_OFS_CTRL) begin
        n.rdata = 32'(q.ctrl);
      end else if (s_axi_araddr == `MCS_OFS_MASK) begin
        n.rdata = {29'h0, q.mask};
      end else if (s_axi_araddr == `MCS_OFS_STATUS) begin
        n.rdata = {29'h0, q.sts};
        n.sts = 3'h0;
      end else if (s_axi_araddr == `MCS_OFS_STATE) begin
        n.rdata = {29'h0, comp_s, q.ready, q.state_bit};
      end else if (s_axi_araddr == `MCS_OFS_ZCAP) begin
        n.rdata = 32'(q.zcap);
      end else if (s_axi_araddr == `MCS_OFS_DCAP) begin
        n.rdata = 32'(q.dcap);
      end else if (s_axi_araddr == `MCS_OFS_TCAP) begin
        n.rdata = 32'(q.tcap);
      end else begin
        n.rresp = `MCS_RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;

    n.sts = n.sts | ev;
    n.irq = |(n.sts & n.mask);
    n.ref_pm = mcs_ref_pm(n.ctrl.vr);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= mcs_ctrl_t'(`MCS_CTRL_RST);
      q.mask <= `MCS_MASK_RST;
      q.ref_pm <= 10'h028;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign ref_threshold_sel = q.ctrl.vr;
  assign ref_permille = q.ref_pm;
  assign comp_clk_en = q.ctrl.cke;
  assign ref_dac_en = q.ctrl.dac_en;
  assign sampled_comparator_state = q.state_bit;
  assign sampling_ready = q.ready;
  assign zero_cross_event = q.z_evt;
  assign demag_event = q.d_evt;
  assign irq = q.irq;

  // Helper counters read only by the checks below
  logic [7:0] h_since_on;
  logic [5:0] h_gap;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_since_on <= 8'h00;
      h_gap <= 6'h00;
    end else begin
      h_since_on <= pdo_on ? 8'h01 : 8'(h_since_on + 8'h01);
      h_gap <= tick ? 6'h01 : 6'(h_gap + 6'h01);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_comp_toggle;
    q.ready && (q.ctrl.mode == mcs_mode_scf) && $changed(comp_s);
  endsequence

  a_tacho_capture: assert property (
    tach_tog |-> ##4 (q.tcap == $past(commutation_timer)))
    else $error("tacho capture not four cycles after toggle");

  a_offtime_zcap: assert property (
    (q.ready && q.ctrl.mode == mcs_mode_offtime && pdo_on &&
     comp_s != q.state_bit && !q.ctrl.demag_sel)
    |-> ##3 (q.zcap == $past(commutation_timer)) && q.z_evt)
    else $error("zero-cross capture not three cycles after phase on");

  a_offtime_state: assert property (
    (q.ready && q.ctrl.mode == mcs_mode_offtime && pdo_on)
    |=> (q.state_bit == $past(comp_s)))
    else $error("sampled state not updated one cycle after phase on");

  // Fastest divider only: a held toggle must be sampled within one period
  a_scf_zero_cross: assert property (
    (s_comp_toggle ##0 (q.ctrl.scf == 2'h0 && comp_s != q.state_bit)
     ##1 $stable(comp_s)[*3])
    |-> ##[0:3] (q.z_evt || q.d_evt))
    else $error("zero-cross event late in sampling-clock mode");

  a_demag_event: assert property (
    (q.cap_pipe[1] && q.ctrl.demag_sel)
    |=> q.d_evt && (q.dcap == $past(commutation_timer)))
    else $error("demag capture missing");

  a_ondelay_state: assert property (
    (smp && q.ctrl.mode == mcs_mode_ondelay && q.ctrl.ds != 8'h00)
    |-> (h_since_on == q.ctrl.ds) ##1 (q.state_bit == $past(comp_s)))
    else $error("on-time sample not at programmed delay");

  a_startup_wait: assert property (
    $rose(q.ready) |-> $past(q.su_cnt) == SUW'(STARTUP_CYC - 1)
    && (q.ctrl.cke || q.ctrl.dac_en))
    else $error("start-up wait ended early");

  a_no_early_sample: assert property (
    !q.ready |-> !smp && !tach_tog)
    else $error("sampling during start-up wait");

  a_ref_table: assert property (
    (q.ctrl.vr == 3'h6) |-> (ref_permille == 10'h2BC))
    else $error("reference fraction wrong for code 110");

  a_scf_period: assert property (
    (tick && $stable(q.ctrl.scf) && $past(q.ready)) |=>
    !tick ##0 (h_gap == 6'h01))
    else $error("sampling tick spacing wrong");

  a_sync_depth: assert property (
    $past(q.ready, 2) |-> comp_s == $past(comp_out, 2))
    else $error("comparator synchroniser depth wrong");

  a_irq_level: assert property (
    irq == |(q.sts & q.mask))
    else $error("interrupt not matching masked status");
endmodule

/* mcs_far_model.sv */
// Purpose: comparator and phase PWM model at the far side of the sampler
// Assumes: comparator output moves asynchronously, phase lines on clk
// Notes: callers invoke the tasks just after a rising edge
module mcs_far_model (
  // Clock
  input wire logic clk,
  // Motor side
  output logic comp_out,
  output logic [5:0] phase_drive_output
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    comp_out = 1'b0;
    phase_drive_output = 6'h00;
  end

  // Lands mid-cycle, like a real comparator, so the synchroniser is needed
  task automatic comp_set(input logic v);
    comp_out <= #37 v;
  endtask

  task automatic phase_set(input logic [5:0] v);
    phase_drive_output <= v;
  endtask
endmodule

/* test_mcs_motor_sampler.sv */
// Purpose: self-checking bench of the motor comparator sampling stage
// Assumes: short start-up count; timer input is a free cycle count
// Notes: latencies count edges from the edge that launched the stimulus
`include "mcs_params.svh"
module test_mcs_motor_sampler
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SU = 4;
  localparam int PM[8] = '{40, 120, 200, 300, 400, 500, 700, 0};
  logic clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic comp_out, rotor_sense_input, comp_clk_en, ref_dac_en;
  logic [5:0] phase_drive_output;
  logic [15:0] commutation_timer;
  logic [2:0] ref_threshold_sel;
  logic [9:0] ref_permille;
  logic sampled_comparator_state, sampling_ready, irq;
  logic zero_cross_event, demag_event;
  int cyc_cnt, n_mismatch, total_checks;

  mcs_motor_sampler #(.TW(16), .STARTUP_CYC(SU)) uut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .comp_out, .rotor_sense_input,
    .phase_drive_output, .commutation_timer, .ref_threshold_sel,
    .ref_permille, .comp_clk_en, .ref_dac_en, .sampled_comparator_state,
    .sampling_ready, .zero_cross_event, .demag_event, .irq);
  mcs_far_model far (.clk, .comp_out, .phase_drive_output);

  assign commutation_timer = cyc_cnt[15:0];
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Timer and watchdog share one count; far above the expected run
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 10000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lat(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw, w;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar;
    @(posedge clk);
    ar = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk_val(d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_rdy(output int n);
    n = 0;
    #1;
    while (sampling_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // A rewrite of CTRL may restart the start-up wait, so always wait
  task automatic setc(input mcs_ctrl_t c);
    int n;
    wr(`MCS_OFS_CTRL, 32'(c));
    wait_rdy(n);
  endtask
  task automatic track(input logic ds, output int ks, output int ke,
                       output logic [15:0] cap);
    logic s0;
    s0 = sampled_comparator_state;
    ks = -1;
    ke = -1;
    for (int k = 1; k <= 300 && ke < 0; k++) begin
      @(posedge clk);
      if (ks < 0 && sampled_comparator_state !== s0)
        ks = k;
      if ((ds ? demag_event : zero_cross_event) === 1'b1) begin
        ke = k;
        cap = 16'(cyc_cnt - 1);
      end
    end
  endtask
  task automatic sample_case(input logic [1:0] md, input logic [7:0] ds,
                             input logic dsel, input logic [2:0] msk);
    mcs_ctrl_t c;
    int ks, ke, d;
    logic [15:0] cap;
    c = '0;
    c.mode = mcs_mode_t'(md);
    c.cke = 1'b1;
    c.ds = ds;
    c.demag_sel = dsel;
    d = (md == 2'd2) ? int'(ds) : 0;
    wr(`MCS_OFS_MASK, 32'(msk));
    setc(c);
    @(posedge clk);
    far.phase_set(6'h00);
    far.comp_set(~sampled_comparator_state);
    cyc(4);
    @(posedge clk);
    far.phase_set(6'h04);
    track(dsel, ks, ke, cap);
    chk_lat(ks, d + 2);
    chk_lat(ke, d + 4);
    rd(dsel ? `MCS_OFS_DCAP : `MCS_OFS_ZCAP, 32'(cap));
    chk_val(32'(irq), 32'(|(msk & (dsel ? 3'h2 : 3'h1))));
    rd(`MCS_OFS_STATUS, dsel ? 32'h2 : 32'h1);
    cyc(1);
    chk_val(32'(irq), 32'h0);
  endtask
  task automatic scf_case(input logic [1:0] sc);
    mcs_ctrl_t c;
    int ks, ke, p;
    logic [15:0] cap;
    p = 4 << sc;
    c = '0;
    c.mode = mcs_mode_scf;
    c.scf = sc;
    c.cke = 1'b1;
    c.demag_sel = sc[0];
    setc(c);
    @(posedge clk);
    far.comp_set(~comp_out);
    track(sc[0], ks, ke, cap);
    chk_lat(int'(ke >= 4 && ke <= p + 6), 1);
    // Toggling on the event edge pins the next sample to one period, except at divide by 4
    far.comp_set(~comp_out);
    track(sc[0], ks, ke, cap);
    if (sc != 2'd0)
      chk_lat(ke, p);
    rd(sc[0] ? `MCS_OFS_DCAP : `MCS_OFS_ZCAP, 32'(cap));
    rd(`MCS_OFS_STATUS, sc[0] ? 32'h2 : 32'h1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    mcs_ctrl_t c;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    {cyc_cnt, n_mismatch, total_checks} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, rotor_sense_input} = '0;
    s_axi_wstrb = 4'hF;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`MCS_OFS_CTRL, 32'h0);
    rd(`MCS_OFS_MASK, 32'h0);
    rd(`MCS_OFS_STATUS, 32'h0);
    chk_val(32'(ref_permille), 32'h28);
    axr(8'h1C, d, r);
    chk_val(d, 32'h0);
    chk_val(32'(r), 32'h2);
    axw(8'h1C, 32'hFFFF, r);
    chk_val(32'(r), 32'h2);
    wr(`MCS_OFS_ZCAP, 32'hFFFF);
    rd(`MCS_OFS_ZCAP, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      c = '0;
      c.vr = 3'(i);
      c.ds = 8'(i * 33);
      wr(`MCS_OFS_CTRL, 32'(c));
      rd(`MCS_OFS_CTRL, 32'(c));
      chk_val(32'(ref_threshold_sel), 32'(i));
      chk_val(32'(ref_permille), 32'(PM[i]));
    end
    $display("test thresholds done");
    for (int i = 0; i < 2; i++) begin
      c = '0;
      c.cke = (i == 0);
      c.dac_en = (i == 1);
      wr(`MCS_OFS_CTRL, 32'(c));
      chk_val(32'({comp_clk_en, ref_dac_en}), 32'({c.cke, c.dac_en}));
      wait_rdy(n);
      chk_lat(n, SU - 1);
      wr(`MCS_OFS_CTRL, 32'h0);
      cyc(0);
      chk_val(32'(sampling_ready), 32'h0);
    end
    $display("test start-up done");
    sample_case(2'd0, 8'd9, 1'b0, 3'h0);
    sample_case(2'd0, 8'd0, 1'b1, 3'h7);
    sample_case(2'd2, 8'd0, 1'b0, 3'h7);
    sample_case(2'd2, 8'd5, 1'b1, 3'h7);
    sample_case(2'd2, 8'd255, 1'b0, 3'h1);
    $display("test phase sampling done");
    for (int i = 0; i < 4; i++)
      scf_case(2'(i));
    $display("test sampling clock done");
    c = '0;
    c.mode = mcs_mode_tacho;
    c.cke = 1'b1;
    setc(c);
    @(posedge clk);
    rotor_sense_input <= ~rotor_sense_input;
    d = 32'(cyc_cnt[15:0] + 16'h0004);
    cyc(8);
    rd(`MCS_OFS_TCAP, d);
    rd(`MCS_OFS_STATUS, 32'h4);
    $display("test tacho done");
    test_done();
  end
endmodule
